// file: verif/sar_adc_props.sv
`timescale 1ns/100ps
`default_nettype none
module sar_adc_props (
  input wire logic       clk_sys_in,
  input wire logic       nrst_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       sleep_in,
  input wire logic [9:0] dac_code_out,
  input wire logic       sample_out,
  input wire logic       analog_on_out,
  input wire logic       wake_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  chk_rdata_quiet: assert property (
    !$past(rd_in) |-> rdata_out == 8'h00) else $error("stray read data");
  chk_trial_onehot: assert property (
    $onehot0(dac_code_out)) else $error("trial code not one-hot");
  chk_msb_first: assert property (
    $rose(|dac_code_out) |-> dac_code_out == 10'h200)
    else $error("first trial not bit 9");
  chk_trial_step: assert property (
    $changed(dac_code_out) && |$past(dac_code_out) && |dac_code_out
    |-> dac_code_out == ($past(dac_code_out) >> 1))
    else $error("trial bit skipped");
  chk_sleep_halt: assert property (
    sleep_in [*3] |-> dac_code_out == 10'h000 && !analog_on_out)
    else $error("converter runs in sleep");
  chk_sample_idle: assert property (
    sample_out |-> dac_code_out == 10'h000 && analog_on_out)
    else $error("sampling while converting");
  chk_off_stops: assert property (
    wr_in && addr_in == 3'h0 && !wdata_in[0] |-> ##2 dac_code_out == 10'h000)
    else $error("converter off but busy");
  chk_wake_sleep: assert property (
    wake_out |-> $past(sleep_in)) else $error("wake outside sleep");
endmodule
`default_nettype wire

// file: verif/test_sar_adc_conversion_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_sar_adc_conversion_control;
  logic       clk_sys_in = 1'h0, nrst_in = 1'h0, wr_in = 1'h0, rd_in = 1'h0;
  logic       comp_in = 1'h0, sleep_in = 1'h0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00, rdata_out;
  logic [9:0] dac_code_out, prev, rnd = 10'h053;
  logic [4:0] chan_sel_out;
  logic       sample_out, analog_on_out, conv_irq_out, wake_out, irq_out;
  integer     err_total = 0, n_compared = 0, cycles = 0, i, n;
  // Divide by 8 stays legal at a 200 MHz clock; RC run awake too
  integer     per [5] = '{800, 16, 32, 64, 8};
  logic [2:0] code [5] = '{3'h3, 3'h5, 3'h2, 3'h6, 3'h1};
  sar_adc_conversion_control i_dut (.*);
  always #2.5 clk_sys_in = ~clk_sys_in;
  // Comparator answers from the target value at the trial bit
  always @(posedge clk_sys_in) comp_in <= |(dac_code_out & rnd);
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      complete_run;
    end
  end
  function logic [9:0] lfsr(input logic [9:0] v);
    lfsr = {v[8:0], v[9] ^ v[6]};
  endfunction
  task chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'h1;
    @(posedge clk_sys_in);
    wr_in <= 1'h0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'h1;
    @(posedge clk_sys_in);
    rd_in <= 1'h0;
    @(negedge clk_sys_in);
    chk(rdata_out, e);
  endtask
  task reset_chk;
    nrst_in <= 1'h0;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'h1;
    for (i = 0; i < 8; i++) rd(i[2:0], 8'h00);
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    reset_chk;
    wr(3'h7, 8'h03);
    for (i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      wr(3'h5, {1'h0, code[i][0], 6'h00});
      wr(3'h1, {1'h0, code[i], 4'h0});
      wr(3'h0, 8'h01);
      wr(3'h0, 8'h03);
      n = 0;
      while (irq_out !== 1'h1 && n < 9000) begin
        @(posedge clk_sys_in);
        n++;
      end
      chk(n >= 11 * per[i] - 2 && n <= 11 * per[i] + 4, 1);
      chk(conv_irq_out, code[i][0]);
      rd(3'h2, {6'h00, rnd[9:8]});
      rd(3'h3, rnd[7:0]);
      rd(3'h0, 8'h01);
      rd(3'h4, 8'h40);
      rd(3'h6, 8'h01);
      wr(3'h4, 8'h00);
      rd(3'h6, 8'h00);
      @(negedge clk_sys_in);
      chk({irq_out, conv_irq_out}, 0);
    end
    prev = rnd;
    rnd = lfsr(rnd);
    wr(3'h0, 8'h03);
    repeat (20) @(posedge clk_sys_in);
    wr(3'h0, 8'h01);
    repeat (4) @(posedge clk_sys_in);
    #1;
    chk(sample_out, 0);
    repeat (16) @(posedge clk_sys_in);
    #1;
    chk(sample_out, 1);
    rd(3'h2, {6'h00, prev[9:8]});
    rd(3'h3, prev[7:0]);
    rd(3'h4, 8'h00);
    rd(3'h6, 8'h02);
    wr(3'h0, 8'h03);
    repeat (10) @(posedge clk_sys_in);
    sleep_in <= 1'h1;
    repeat (5) @(posedge clk_sys_in);
    #1;
    chk(analog_on_out, 0);
    rd(3'h0, 8'h01);
    sleep_in <= 1'h0;
    wr(3'h0, 8'h03);
    repeat (30) @(posedge clk_sys_in);
    wr(3'h0, 8'h00);
    repeat (4) @(posedge clk_sys_in);
    rd(3'h0, 8'h00);
    wr(3'h0, 8'h01);
    wr(3'h0, 8'h03);
    repeat (30) @(posedge clk_sys_in);
    reset_chk;
    complete_run;
  end
endmodule
bind sar_adc_conversion_control sar_adc_props i_props (.*);
`default_nettype wire

// file: verilog/bit_period_gen.v
`timescale 1ns/100ps
`default_nettype none
// Makes a one-cycle tick at the end of each bit period
module bit_period_gen (
  // Clock and reset
  input  wire       clk_sys_in,
  input  wire       nrst_in,
  // Control
  input  wire       run_in,
  input  wire [9:0] half_in,
  // Tick
  output reg        tick_out
);
  reg [9:0] count;
  reg       phase;

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count    <= 10'h000;
      phase    <= 1'b0;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      count    <= 10'h000;
      phase    <= 1'b0;
      tick_out <= 1'b0;
    end else if (count >= half_in) begin
      count    <= 10'h000;
      phase    <= ~phase;
      tick_out <= phase;
    end else begin
      count    <= count + 10'h001;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verilog/sar_adc_conversion_control.v
// Overview of operation
// [R1] Clock select 001/101/010/110 divide by 8/16/32/64; x11 selects RC clock.
// [R2] A conversion lasts eleven bit periods from its start.
// [R3] Only the second control register clock field picks the clock.
// [R4] Software avoids divide by 8 at 8 MHz system clock.
// [R5] Software picks RC clock only for conversions during sleep.
// [R6] Done flag sets at every conversion end regardless of enable.
// [R7] Hardware never clears done flag; software clears it by write.
// [R8] Interrupt request when done flag and its enable are both set.
// [R9] Pending interrupt wakes from sleep and also fires in normal run.
// [R10] Result right-justified: low byte bits 7..0, high byte bits 9..8.
// [R11] Converter works only while on; writing go starts a conversion.
// [R12] Software turns converter on before setting go in later write.
// [R13] After period eleven: load result, clear go, set done together.
// [R14] Clearing go mid-conversion aborts; result keeps previous value.
// [R15] After abort wait two bit periods, then acquisition restarts itself.
// [R16] Reset returns registers to reset values, converter off, stops conversion.
// [R17] Converter does not operate while the device sleeps.
// [R18] One bit per period, MSB first, bit 9 in period 2.
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_defs.vh"
module sar_adc_conversion_control (
  // Clock and reset
  input  wire       clk_sys_in,
  input  wire       nrst_in,
  // Register port
  input  wire [2:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  // Analog side
  input  wire       comp_in,
  input  wire       sleep_in,
  output reg  [9:0] dac_code_out,
  output reg  [4:0] chan_sel_out,
  output reg        sample_out,
  output reg        analog_on_out,
  // Interrupts
  output reg        conv_irq_out,
  output reg        wake_out,
  output reg        irq_out
);
  localparam ST_IDLE  = 4'b0001;
  localparam ST_CONV  = 4'b0010;
  localparam ST_ABORT = 4'b0100;
  localparam ST_DONE  = 4'b1000;

  reg [3:0] state;
  reg [3:0] next_state;
  reg       converter_on;
  reg       go_busy;
  reg [4:0] chan;
  reg [2:0] conv_clock_select;
  reg       conv_done_flag;
  reg       conv_irq_enable;
  reg [7:0] result_low_byte;
  reg [1:0] result_high_byte;
  reg [9:0] sar;
  reg [3:0] period_cnt;
  reg [1:0] status;
  reg [1:0] mask;
  reg [9:0] half;
  reg       sar_set;
  wire      tick;
  wire      run;
  wire      wr_first;
  wire      go_write;
  wire      go_clear;
  wire      finish;
  wire      abort_evt;
  wire      pend;
  wire      hold_on;

  assign run = converter_on && !sleep_in; // R17 R11
  assign wr_first = wr_in && (addr_in == `OFS_CTRL_FIRST);
  assign go_write = wr_first && wdata_in[`BIT_GO_BUSY];
  assign go_clear = wr_first && !wdata_in[`BIT_GO_BUSY];
  assign finish = (state == ST_CONV) && tick &&
                  (period_cnt == (`CONV_PERIODS - 4'h1)); // R2
  assign abort_evt = (state == ST_CONV) && (go_clear || !run); // R14
  assign pend = conv_done_flag && conv_irq_enable; // R8
  assign hold_on = wr_first && wdata_in[`BIT_CONVERTER_ON];

  // Bit period selection
  always @* begin
    case (conv_clock_select) // R1 R3
      `CLKSEL_DIV8:  half = {4'h0, `HALF_DIV8};
      `CLKSEL_DIV16: half = {4'h0, `HALF_DIV16};
      `CLKSEL_DIV32: half = {4'h0, `HALF_DIV32};
      `CLKSEL_DIV64: half = {4'h0, `HALF_DIV64};
      default: begin
        if (conv_clock_select[1:0] == 2'b11)
          half = `RC_HALF;
        else
          half = {4'h0, `HALF_DIV8};
      end
    endcase
  end

  bit_period_gen u_bit_period_gen (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .run_in     (run && (state != ST_IDLE)),
    .half_in    (half),
    .tick_out   (tick)
  );

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (go_write && run && converter_on)
          next_state = ST_CONV;
      ST_CONV:
        if (abort_evt)
          next_state = ST_ABORT;
        else if (finish)
          next_state = ST_DONE;
      ST_ABORT:
        if (!run ||
            (tick && period_cnt == {2'b00, `ABORT_PERIODS - 2'h1}))
          next_state = ST_IDLE; // R15
      ST_DONE:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // Control and SAR sequencing
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin // R16
      state             <= ST_IDLE;
      converter_on      <= 1'b0;
      go_busy           <= 1'b0;
      chan              <= 5'h00;
      conv_clock_select <= 3'h0;
      conv_done_flag    <= 1'b0;
      conv_irq_enable   <= 1'b0;
      result_low_byte   <= 8'h00;
      result_high_byte  <= 2'h0;
      sar               <= 10'h000;
      period_cnt        <= 4'h0;
      status            <= 2'h0;
      mask              <= 2'h0;
      sar_set           <= 1'b0;
    end else begin
      state <= next_state;
      if (wr_first) begin
        converter_on <= wdata_in[`BIT_CONVERTER_ON]; // R11
        chan         <= wdata_in[`CHAN_MSB:`CHAN_LSB];
      end
      if (wr_in && addr_in == `OFS_CTRL_SECOND)
        conv_clock_select <= wdata_in[`CLKSEL_MSB:`CLKSEL_LSB]; // R3
      if (wr_in && addr_in == `OFS_ENABLE_REG)
        conv_irq_enable <= wdata_in[`BIT_IRQ_ENABLE];
      if (wr_in && addr_in == `OFS_IRQ_MASK)
        mask <= wdata_in[1:0];
      // Go only starts from idle when already on
      if (state == ST_IDLE && go_write && run && converter_on)
        go_busy <= 1'b1; // R11
      else if (finish || abort_evt || (state == ST_IDLE && !hold_on))
        go_busy <= 1'b0; // R13 R14
      else if (state == ST_IDLE)
        go_busy <= 1'b0;
      // Period count and SAR
      if (state == ST_IDLE) begin
        period_cnt <= 4'h0;
        sar        <= 10'h000;
        sar_set    <= 1'b0;
      end else if (abort_evt) begin
        period_cnt <= 4'h0;
      end else if (tick) begin
        period_cnt <= period_cnt + 4'h1;
        if (state == ST_CONV && period_cnt >= 4'h1 &&
            period_cnt <= 4'ha) begin
          // Keep the trial bit if the comparator says below input
          sar <= sar | (comp_in ? dac_code_out : 10'h000); // R18
          sar_set <= 1'b1;
        end
      end
      if (finish) begin // R13 R10
        result_low_byte  <= sar[7:0] | (comp_in ? dac_code_out[7:0] : 8'h00);
        result_high_byte <= sar[9:8] | (comp_in ? dac_code_out[9:8] : 2'h0);
      end
      // Set wins over a software clear
      if (finish)
        conv_done_flag <= 1'b1; // R6
      else if (wr_in && addr_in == `OFS_FLAG_REG)
        conv_done_flag <= wdata_in[`BIT_DONE_FLAG]; // R7
      status <= (rd_in && addr_in == `OFS_IRQ_STATUS) ? 2'h0 : status;
      if (finish)
        status[`EVT_DONE] <= 1'b1;
      if (abort_evt)
        status[`EVT_ABORT] <= 1'b1;
    end
  end

  // Trial code: only the bit under test, one-hot, without the current SAR
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dac_code_out  <= 10'h000;
      chan_sel_out  <= 5'h00;
      sample_out    <= 1'b0;
      analog_on_out <= 1'b0;
    end else begin
      chan_sel_out  <= chan;
      analog_on_out <= run; // R17
      sample_out    <= run && (state == ST_IDLE); // R15
      if (state == ST_CONV && period_cnt <= 4'ha)
        dac_code_out <= 10'h200 >> ((period_cnt == 4'h0) ? 4'h0 :
                        (tick ? period_cnt : period_cnt - 4'h1)); // R18
      else
        dac_code_out <= 10'h000;
    end
  end

  // Read data and interrupt outputs
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out    <= 8'h00;
      conv_irq_out <= 1'b0;
      wake_out     <= 1'b0;
      irq_out      <= 1'b0;
    end else begin
      conv_irq_out <= pend; // R8 R9
      wake_out     <= pend && sleep_in; // R9
      irq_out      <= |(status & mask);
      rdata_out    <= 8'h00;
      if (rd_in) begin
        case (addr_in)
          `OFS_CTRL_FIRST:
            rdata_out <= {1'b0, chan, go_busy, converter_on};
          `OFS_CTRL_SECOND:
            rdata_out <= {1'b0, conv_clock_select, 4'h0};
          `OFS_RESULT_HIGH:
            rdata_out <= {6'h00, result_high_byte}; // R10
          `OFS_RESULT_LOW:
            rdata_out <= result_low_byte; // R10
          `OFS_FLAG_REG:
            rdata_out <= {1'b0, conv_done_flag, 6'h00};
          `OFS_ENABLE_REG:
            rdata_out <= {1'b0, conv_irq_enable, 6'h00};
          `OFS_IRQ_STATUS:
            rdata_out <= {6'h00, status};
          `OFS_IRQ_MASK:
            rdata_out <= {6'h00, mask};
          default:
            rdata_out <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/sar_adc_defs.vh
`ifndef SAR_ADC_DEFS_VH
`define SAR_ADC_DEFS_VH

// Register offsets
`define OFS_CTRL_FIRST    3'h0
`define OFS_CTRL_SECOND   3'h1
`define OFS_RESULT_HIGH   3'h2
`define OFS_RESULT_LOW    3'h3
`define OFS_FLAG_REG      3'h4
`define OFS_ENABLE_REG    3'h5
`define OFS_IRQ_STATUS    3'h6
`define OFS_IRQ_MASK      3'h7

// First control register fields
`define BIT_CONVERTER_ON  0
`define BIT_GO_BUSY       1
`define CHAN_LSB          2
`define CHAN_MSB          6

// Second control register fields
`define CLKSEL_LSB        4
`define CLKSEL_MSB        6

// Flag and enable register fields
`define BIT_DONE_FLAG     6
`define BIT_IRQ_ENABLE    6

// Interrupt status bits
`define EVT_DONE          0
`define EVT_ABORT         1

// Clock select codes
`define CLKSEL_DIV8       3'h1
`define CLKSEL_DIV16      3'h5
`define CLKSEL_DIV32      3'h2
`define CLKSEL_DIV64      3'h6

// Divider reload values (half periods minus one)
`define HALF_DIV8         6'h03
`define HALF_DIV16        6'h07
`define HALF_DIV32        6'h0f
`define HALF_DIV64        6'h1f
// Internal RC bit period: nominal 4 us at 200 MHz
`define RC_PERIOD_NS      4000
`define CLK_PERIOD_NS     5
// Half period minus one: (4000 / 5) / 2 - 1
`define RC_HALF           10'h18f

// Timing counts in bit periods
`define CONV_PERIODS      4'hb
`define ABORT_PERIODS     2'h2

`endif
